// ===== common/sdf_pkg.sv
// Package: constants for the stepper drive fault latch block
// Summary of operation
// - Drive type minus two selects bipolar stepper
// - Two-bit code picks 0.5/1/2/3 A per phase
// - Hold setting zero gives full hold current
// - Hold setting one gives quarter hold current
// - Over-current and under-voltage reported as faults
// - Fault triggers jump to handler when present
// - Fault report is an eight-bit bitmask
// - Report shows latch per bank A-D, E-H
// - Short circuit: over-current, disable, latch
// - Under-voltage latches, clear refused while low
// - Halt with cutoff jumper disables, latches fault
// - All idle, nothing latched: report is live
// - Bank latches only with a holding axis
// - Eight analog inputs, twelve bits, plus/minus ten volts
// - Analog read returns selected input value
package sdf_pkg;
  localparam int AXES = 8;
  localparam int ADC_BITS = 12;
  localparam int ADDR_W = 4;
  // Register offsets
  localparam logic [3:0] OFF_DRIVE_TYPE = 4'h0;
  localparam logic [3:0] OFF_CURRENT = 4'h1;
  localparam logic [3:0] OFF_HOLD = 4'h2;
  localparam logic [3:0] OFF_STATE = 4'h3;
  localparam logic [3:0] OFF_FAULT = 4'h4;
  localparam logic [3:0] OFF_CLEAR = 4'h5;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h6;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h7;
  localparam logic [3:0] OFF_ADC_SEL = 4'h8;
  localparam logic [3:0] OFF_ADC_VAL = 4'h9;
  localparam logic [3:0] OFF_HANDLER = 4'hA;
  // Drive type code for bipolar stepper (minus two, 4-bit two's complement)
  localparam logic [3:0] DRIVE_BIPOLAR = 4'hE;
  localparam logic [3:0] DRIVE_TYPE_RST = 4'h1;
  localparam logic [1:0] CURRENT_RST = 2'h0;
  localparam logic [7:0] CLEAR_ARG = 8'h01;
  // Fault report bit positions
  localparam int FB_OC_AD = 0;
  localparam int FB_UV_AD = 1;
  localparam int FB_CUT_AD = 2;
  localparam int FB_OC_EH = 3;
  localparam int FB_UV_EH = 4;
  localparam int FB_CUT_EH = 5;
  localparam int FB_LATCH_AD = 6;
  localparam int FB_LATCH_EH = 7;
  // Interrupt status bits
  localparam int IB_FAULT_AD = 0;
  localparam int IB_FAULT_EH = 1;
  localparam int IB_HANDLER = 2;
  localparam int IB_CLEARED = 3;
  localparam int IRQ_W = 4;
  // Axis state codes
  localparam logic [1:0] ST_IDLE = 2'h0;
  localparam logic [1:0] ST_HOLD = 2'h1;
  localparam logic [1:0] ST_MOVE = 2'h2;
  // Hold current percentages
  localparam logic [6:0] HOLD_FULL_PCT = 7'h64;
  localparam logic [6:0] HOLD_LOW_PCT = 7'h19;
endpackage

// ===== hw/sdf_top.sv
// Module: stepper drive configuration, fault latching and analog readout
`timescale 1ns/10ps
`default_nettype none
module sdf_top #(
  parameter int AXES = 8
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [1:0] OVERCURRENT_IN,
  input wire logic [1:0] UNDERVOLT_IN,
  input wire logic HALT_IN,
  input wire logic CUTOFF_JUMPER_IN,
  input wire logic HANDLER_PRESENT,
  input wire logic [95:0] ADC_DATA_IN,
  output logic [7:0] STEPPER_MODE,
  output logic [15:0] PHASE_CURRENT,
  output logic [55:0] HOLD_PERCENT,
  output logic [7:0] POWER_ENABLE,
  output logic HANDLER_JUMP,
  output logic IRQ
);
  localparam int HALF = AXES / 2;
  // Pin synchronisers: first stage read only by the second
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [95:0] adc1_reg;
  logic [95:0] adc2_reg;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      adc1_reg <= 96'h0;
      adc2_reg <= 96'h0;
    end else begin
      sync1_reg <= {CUTOFF_JUMPER_IN, HALT_IN, UNDERVOLT_IN, OVERCURRENT_IN};
      sync2_reg <= sync1_reg;
      adc1_reg <= ADC_DATA_IN;
      adc2_reg <= adc1_reg;
    end
  end
  logic [1:0] oc_s;
  logic [1:0] uv_s;
  logic cut_s;
  assign oc_s = sync2_reg[1:0];
  assign uv_s = sync2_reg[3:2];
  assign cut_s = sync2_reg[4] & sync2_reg[5];

  // Configuration registers
  logic [3:0] drive_type_reg [AXES];
  logic [1:0] current_reg [AXES];
  logic [AXES-1:0] hold_low_reg;
  logic [1:0] state_reg [AXES];
  localparam int IRQ_W_L = sdf_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_mask_reg;
  logic [2:0] adc_sel_reg;
  logic clear_req;
  assign clear_req = WR && (ADDR == sdf_pkg::OFF_CLEAR) &&
                     (WDATA[7:0] == sdf_pkg::CLEAR_ARG);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < AXES; i++) begin
        drive_type_reg[i] <= sdf_pkg::DRIVE_TYPE_RST;
        current_reg[i] <= sdf_pkg::CURRENT_RST;
        state_reg[i] <= sdf_pkg::ST_IDLE;
      end
      hold_low_reg <= '0;
      irq_mask_reg <= '0;
      adc_sel_reg <= 3'h0;
    end else if (WR) begin
      unique case (ADDR)
        sdf_pkg::OFF_DRIVE_TYPE: begin
          for (int i = 0; i < AXES; i++) begin
            drive_type_reg[i] <= WDATA[4*i +: 4];
          end
        end
        sdf_pkg::OFF_CURRENT: begin
          // Only idle axes accept a new current code; others keep theirs
          for (int i = 0; i < AXES; i++) begin
            if (state_reg[i] == sdf_pkg::ST_IDLE) begin
              current_reg[i] <= WDATA[2*i +: 2];
            end
          end
        end
        sdf_pkg::OFF_HOLD: hold_low_reg <= WDATA[AXES-1:0];
        sdf_pkg::OFF_STATE: begin
          for (int i = 0; i < AXES; i++) begin
            state_reg[i] <= WDATA[2*i +: 2];
          end
        end
        sdf_pkg::OFF_IRQ_MASK: irq_mask_reg <= WDATA[IRQ_W_L-1:0];
        sdf_pkg::OFF_ADC_SEL: adc_sel_reg <= WDATA[2:0];
        default: ;
      endcase
    end
  end

  // Bank state
  logic [1:0] bank_hold;
  logic all_idle;
  always_comb begin
    bank_hold = 2'b00;
    all_idle = 1'b1;
    for (int i = 0; i < AXES; i++) begin
      if (state_reg[i] == sdf_pkg::ST_HOLD) begin
        bank_hold[i / HALF] = 1'b1;
      end
      if (state_reg[i] != sdf_pkg::ST_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  // Per-bank latches: {cutoff, undervolt, overcurrent}
  logic [2:0] latch_reg [2];
  logic [1:0] latched;
  logic [2:0] cond [2];
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      cond[b] = {cut_s, uv_s[b], oc_s[b]};
      latched[b] = |latch_reg[b];
    end
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      latch_reg[0] <= 3'h0;
      latch_reg[1] <= 3'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        // Clear first, then a present condition sets again: set wins
        if (clear_req) begin
          // Under-voltage bit survives while supply still low
          latch_reg[b] <= {1'b0, uv_s[b] & latch_reg[b][1], 1'b0};
        end
        if (bank_hold[b]) begin
          latch_reg[b] <= (clear_req ? {1'b0, uv_s[b] & latch_reg[b][1], 1'b0}
                                     : latch_reg[b]) | cond[b];
        end
      end
    end
  end

  // Fault report: live while idle and unlatched, latched otherwise
  logic [7:0] fault_report;
  logic [2:0] shown [2];
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      shown[b] = (all_idle && !latched[0] && !latched[1]) ? cond[b]
                                                         : latch_reg[b];
    end
    fault_report = {latched[1], latched[0], shown[1], shown[0]};
  end

  // Fault events and handler jump
  logic [1:0] latched_d_reg;
  logic [IRQ_W_L-1:0] irq_stat_reg;
  logic [IRQ_W_L-1:0] irq_event;
  logic rd_stat;
  logic new_fault;
  assign new_fault = |(latched & ~latched_d_reg);
  assign rd_stat = RD && (ADDR == sdf_pkg::OFF_IRQ_STAT);
  always_comb begin
    irq_event = '0;
    irq_event[sdf_pkg::IB_FAULT_AD] = latched[0] & ~latched_d_reg[0];
    irq_event[sdf_pkg::IB_FAULT_EH] = latched[1] & ~latched_d_reg[1];
    irq_event[sdf_pkg::IB_HANDLER] = new_fault & HANDLER_PRESENT;
    irq_event[sdf_pkg::IB_CLEARED] = clear_req;
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      latched_d_reg <= 2'b00;
      HANDLER_JUMP <= 1'b0;
      irq_stat_reg <= '0;
      IRQ <= 1'b0;
    end else begin
      latched_d_reg <= latched;
      HANDLER_JUMP <= new_fault & HANDLER_PRESENT;
      // Read clears, but an event in the same cycle survives
      irq_stat_reg <= (rd_stat ? '0 : irq_stat_reg) | irq_event;
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Drive outputs
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      STEPPER_MODE <= 8'h00;
      PHASE_CURRENT <= 16'h0000;
      HOLD_PERCENT <= 56'h0;
      POWER_ENABLE <= 8'h00;
    end else begin
      for (int i = 0; i < AXES; i++) begin
        STEPPER_MODE[i] <= (drive_type_reg[i] == sdf_pkg::DRIVE_BIPOLAR);
        PHASE_CURRENT[2*i +: 2] <= current_reg[i];
        HOLD_PERCENT[7*i +: 7] <= hold_low_reg[i] ? sdf_pkg::HOLD_LOW_PCT
                                                  : sdf_pkg::HOLD_FULL_PCT;
        // Any latched fault of the bank, or the cutoff, drops the stage
        POWER_ENABLE[i] <= (state_reg[i] != sdf_pkg::ST_IDLE) &&
                           !latched[i / HALF] && !cut_s;
      end
    end
  end

  // Read port: data one cycle after the strobe
  logic [31:0] rd_mux;
  localparam int ADC_BITS_L = sdf_pkg::ADC_BITS;
  logic [11:0] adc_word;
  assign adc_word = adc2_reg[ADC_BITS_L*adc_sel_reg +: 12];
  always_comb begin
    rd_mux = 32'h0;
    unique case (ADDR)
      sdf_pkg::OFF_DRIVE_TYPE: begin
        for (int i = 0; i < AXES; i++) rd_mux[4*i +: 4] = drive_type_reg[i];
      end
      sdf_pkg::OFF_CURRENT: begin
        for (int i = 0; i < AXES; i++) rd_mux[2*i +: 2] = current_reg[i];
      end
      sdf_pkg::OFF_HOLD: rd_mux[7:0] = hold_low_reg;
      sdf_pkg::OFF_STATE: begin
        for (int i = 0; i < AXES; i++) rd_mux[2*i +: 2] = state_reg[i];
      end
      sdf_pkg::OFF_FAULT: rd_mux[7:0] = fault_report;
      sdf_pkg::OFF_IRQ_STAT: rd_mux[3:0] = irq_stat_reg;
      sdf_pkg::OFF_IRQ_MASK: rd_mux[3:0] = irq_mask_reg;
      sdf_pkg::OFF_ADC_SEL: rd_mux[2:0] = adc_sel_reg;
      sdf_pkg::OFF_ADC_VAL: rd_mux[11:0] = adc_word;
      sdf_pkg::OFF_HANDLER: rd_mux[0] = HANDLER_PRESENT;
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD ? rd_mux : 32'h0;
    end
  end
endmodule // sdf_top
`default_nettype wire

// ===== verif/sdf_top_properties.sv
// Checker: port-level properties of the drive fault block
`timescale 1ns/10ps
`default_nettype none
module sdf_checker (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic HALT_IN,
  input wire logic CUTOFF_JUMPER_IN,
  input wire logic HANDLER_PRESENT,
  input wire logic [7:0] STEPPER_MODE,
  input wire logic [55:0] HOLD_PERCENT,
  input wire logic [7:0] POWER_ENABLE,
  input wire logic HANDLER_JUMP
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
  property p_jump_once; HANDLER_JUMP |=> !HANDLER_JUMP; endproperty
  property p_jump_cause; HANDLER_JUMP |-> $past(HANDLER_PRESENT); endproperty
  property p_jump_off;
    HANDLER_JUMP |-> POWER_ENABLE[3:0] == 4'h0 || POWER_ENABLE[7:4] == 4'h0;
  endproperty
  // Zero only while the first edge after reset loads the default
  property p_hold;
    $past(RST_N) |-> HOLD_PERCENT[6:0] inside {7'h64, 7'h19};
  endproperty
  property p_cutoff;
    (HALT_IN && CUTOFF_JUMPER_IN) [*8] |-> POWER_ENABLE == 8'h0;
  endproperty
  property p_fault_w; RD && ADDR == 4'h4 |=> RDATA[31:8] == 24'h0; endproperty
  property p_adc_w; RD && ADDR == 4'h9 |=> RDATA[31:12] == 20'h0; endproperty
  property p_mode;
    WR && ADDR == 4'h0 |-> ##2
      STEPPER_MODE[0] == ($past(WDATA[3:0], 2) == sdf_pkg::DRIVE_BIPOLAR);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  a_jump_once: assert property (p_jump_once)
    else $error("handler jump longer than one cycle");
  a_jump_cause: assert property (p_jump_cause)
    else $error("handler jump without handler");
  a_jump_off: assert property (p_jump_off)
    else $error("bank powered at fault latch");
  a_hold: assert property (p_hold)
    else $error("hold percent not 100 or 25");
  a_cutoff: assert property (p_cutoff)
    else $error("power on during cutoff");
  a_fault_w: assert property (p_fault_w)
    else $error("fault report wider than eight bits");
  a_adc_w: assert property (p_adc_w)
    else $error("adc value wider than twelve bits");
  a_mode: assert property (p_mode)
    else $error("stepper mode does not follow drive type");
  c_jump: cover property (HANDLER_JUMP);
  c_cut: cover property (HALT_IN && CUTOFF_JUMPER_IN && POWER_ENABLE == 8'h0);
  c_adc: cover property (RD && ADDR == 4'h9);
endmodule // sdf_checker
bind sdf_top sdf_checker u_chk (.MCLK, .RST_N, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .HALT_IN, .CUTOFF_JUMPER_IN, .HANDLER_PRESENT, .STEPPER_MODE,
  .HOLD_PERCENT, .POWER_ENABLE, .HANDLER_JUMP);
`default_nettype wire

// ===== verif/sdf_stage_model.sv
// Model: power stage and supply monitors feeding the fault block
`timescale 1ns/10ps
`default_nettype none
module sdf_stage_model (
  input wire logic [1:0] short_req,
  input wire logic [1:0] sag_req,
  input wire logic estop_req,
  input wire logic jumper_fit,
  output logic [1:0] OVERCURRENT_IN,
  output logic [1:0] UNDERVOLT_IN,
  output logic HALT_IN,
  output logic CUTOFF_JUMPER_IN,
  output logic [95:0] ADC_DATA_IN
);
  assign OVERCURRENT_IN = short_req;
  assign UNDERVOLT_IN = sag_req;
  assign HALT_IN = estop_req;
  assign CUTOFF_JUMPER_IN = jumper_fit;
  // Distinct code per channel so a wrong select cannot pass
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      ADC_DATA_IN[12*n +: 12] = 12'h801 + 12'h111 * n[11:0];
    end
  end
endmodule // sdf_stage_model
`default_nettype wire

// ===== verif/sdf_top_tb.sv
// Testbench: register-level tests of the drive fault block
`timescale 1ns/10ps
`default_nettype none
module sdf_top_tb;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic HANDLER_PRESENT = 1'b1;
  logic [1:0] short_req = 2'h0, sag_req = 2'h0;
  logic estop_req = 1'b0, jumper_fit = 1'b1;
  logic [1:0] OVERCURRENT_IN, UNDERVOLT_IN;
  logic HALT_IN, CUTOFF_JUMPER_IN, HANDLER_JUMP, IRQ;
  logic [95:0] ADC_DATA_IN;
  logic [31:0] RDATA, rv;
  logic [7:0] STEPPER_MODE, POWER_ENABLE;
  logic [15:0] PHASE_CURRENT;
  logic [55:0] HOLD_PERCENT;
  int miscompares = 0, n_checks = 0, cycles = 0, jumps = 0;
  sdf_stage_model u_stage (.short_req, .sag_req, .estop_req, .jumper_fit,
    .OVERCURRENT_IN, .UNDERVOLT_IN, .HALT_IN, .CUTOFF_JUMPER_IN, .ADC_DATA_IN);
  sdf_top #(.AXES(8)) DUT (.MCLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .OVERCURRENT_IN, .UNDERVOLT_IN, .HALT_IN, .CUTOFF_JUMPER_IN,
    .HANDLER_PRESENT, .ADC_DATA_IN, .STEPPER_MODE, .PHASE_CURRENT,
    .HOLD_PERCENT, .POWER_ENABLE, .HANDLER_JUMP, .IRQ);
  always #5 MCLK = ~MCLK;
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (HANDLER_JUMP === 1'b1) jumps <= jumps + 1;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
    rd(a, rv);
    chk(64'(rv), 64'(exp));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic fault(input logic [1:0] s, u, input logic h);
    @(posedge MCLK);
    short_req <= s;
    sag_req <= u;
    estop_req <= h;
  endtask
  initial begin
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    tick(1);
    chk_reg(sdf_pkg::OFF_DRIVE_TYPE, 32'h11111111);
    chk(64'(HOLD_PERCENT), {8'h0, {8{7'h64}}});
    wr(sdf_pkg::OFF_DRIVE_TYPE, 32'h1E1E1E1E);
    tick(2);
    chk(64'(STEPPER_MODE), 64'h55);
    for (int c = 0; c < 4; c++) begin
      wr(sdf_pkg::OFF_CURRENT, 32'({8{c[1:0]}}));
      tick(2);
      chk(64'(PHASE_CURRENT), 64'({8{c[1:0]}}));
    end
    wr(sdf_pkg::OFF_STATE, 32'h1);
    wr(sdf_pkg::OFF_CURRENT, 32'h0);
    wr(sdf_pkg::OFF_HOLD, 32'hF0);
    tick(2);
    chk(64'(PHASE_CURRENT), 64'h3);
    chk(64'(HOLD_PERCENT), {8'h0, {4{7'h19}}, {4{7'h64}}});
    chk(64'(POWER_ENABLE), 64'h1);
    wr(sdf_pkg::OFF_STATE, 32'h0);
    fault(2'h2, 2'h0, 1'b0);
    tick(4);
    chk_reg(sdf_pkg::OFF_FAULT, 32'h08);
    wr(sdf_pkg::OFF_IRQ_MASK, 32'h0);
    wr(sdf_pkg::OFF_STATE, 32'h1);
    fault(2'h1, 2'h0, 1'b0);
    tick(6);
    chk(64'(POWER_ENABLE), 64'h0);
    chk(64'(IRQ), 64'h0);
    chk(64'(jumps), 64'h1);
    wr(sdf_pkg::OFF_IRQ_MASK, 32'hF);
    tick(2);
    chk(64'(IRQ), 64'h1);
    fault(2'h0, 2'h0, 1'b0);
    chk_reg(sdf_pkg::OFF_FAULT, 32'h41);
    wr(sdf_pkg::OFF_STATE, 32'h0);
    wr(sdf_pkg::OFF_CLEAR, 32'h0);
    chk_reg(sdf_pkg::OFF_FAULT, 32'h41);
    wr(sdf_pkg::OFF_CLEAR, 32'h1);
    chk_reg(sdf_pkg::OFF_FAULT, 32'h0);
    rd(sdf_pkg::OFF_IRQ_STAT, rv);
    chk_reg(sdf_pkg::OFF_IRQ_STAT, 32'h0);
    chk(64'(IRQ), 64'h0);
    wr(sdf_pkg::OFF_STATE, 32'h100);
    fault(2'h0, 2'h2, 1'b0);
    HANDLER_PRESENT <= 1'b0;
    tick(6);
    chk(64'(POWER_ENABLE), 64'h0);
    chk(64'(jumps), 64'h1);
    wr(sdf_pkg::OFF_STATE, 32'h0);
    wr(sdf_pkg::OFF_CLEAR, 32'h1);
    chk_reg(sdf_pkg::OFF_FAULT, 32'h90);
    fault(2'h0, 2'h0, 1'b0);
    HANDLER_PRESENT <= 1'b1;
    tick(3);
    wr(sdf_pkg::OFF_CLEAR, 32'h1);
    chk_reg(sdf_pkg::OFF_FAULT, 32'h0);
    wr(sdf_pkg::OFF_STATE, 32'h1);
    fault(2'h0, 2'h0, 1'b1);
    tick(10);
    chk(64'(POWER_ENABLE), 64'h0);
    rd(sdf_pkg::OFF_FAULT, rv);
    chk(64'(rv & 32'h44), 64'h44);
    chk(64'(jumps), 64'h2);
    for (int n = 0; n < 8; n++) begin
      wr(sdf_pkg::OFF_ADC_SEL, 32'(n));
      chk_reg(sdf_pkg::OFF_ADC_VAL, 32'h801 + 32'h111 * 32'(n));
    end
    chk_reg(sdf_pkg::OFF_HANDLER, 32'h1);
    chk_reg(4'hF, 32'h0);
    conclude();
  end
endmodule // sdf_top_tb
`default_nettype wire
